// ===== design/mra_pkg.sv
// package: register map, field layout and helper functions for the region register block
`default_nettype none
package mra_pkg;

   // ==========================================
   // bus and storage geometry
   localparam int MRA_ADDR_W = 8;                  // axi byte address width
   localparam int MRA_DATA_W = 32;                 // axi data width
   localparam int MRA_NUM_REGIONS = 16;            // four-bit region field
   localparam int MRA_REGION_W = 4;                // width of region number

   // ==========================================
   // register byte offsets
   localparam logic [7:0] MRA_OFS_REGION_NUMBER = 8'h00;  // region_number_selector
   localparam logic [7:0] MRA_OFS_BASE = 8'h04;           // region_base_register
   localparam logic [7:0] MRA_OFS_ATTR = 8'h08;           // region_attr_size_register
   localparam logic [7:0] MRA_OFS_BASE_A1 = 8'h0c;        // base alias one
   localparam logic [7:0] MRA_OFS_ATTR_A1 = 8'h10;        // attr/size alias one
   localparam logic [7:0] MRA_OFS_BASE_A2 = 8'h14;        // region_base_alias_two
   localparam logic [7:0] MRA_OFS_ATTR_A2 = 8'h18;        // region_attr_size_alias_two
   localparam logic [7:0] MRA_OFS_BASE_A3 = 8'h1c;        // region_base_alias_three
   localparam logic [7:0] MRA_OFS_ATTR_A3 = 8'h20;        // region_attr_size_alias_three

   // ==========================================
   // base register fields
   localparam int MRA_BASE_VALID_BIT = 4;          // write-only region-valid bit
   localparam int MRA_BASE_ADDR_LSB = 5;           // lowest stored address bit
   localparam logic [31:0] MRA_BASE_ADDR_MASK = 32'hffffffe0; // stored address bits

   // ==========================================
   // attribute/size register fields
   localparam int MRA_ATTR_XN_BIT = 28;            // execute_never_bit
   localparam int MRA_ATTR_AP_LSB = 24;            // access_permission_field 26:24
   localparam int MRA_ATTR_TEX_LSB = 19;           // type_extension_field 21:19
   localparam int MRA_ATTR_S_BIT = 18;             // shareable
   localparam int MRA_ATTR_C_BIT = 17;             // cacheable
   localparam int MRA_ATTR_B_BIT = 16;             // bufferable
   localparam int MRA_ATTR_SRD_LSB = 8;            // subregion_disable_mask 15:8
   localparam int MRA_ATTR_SIZE_LSB = 1;           // size field 5:1
   localparam int MRA_ATTR_EN_BIT = 0;             // region enable
   localparam logic [31:0] MRA_ATTR_RW_MASK = 32'h173fff3f; // implemented attr bits

   // ==========================================
   // size encodings
   localparam logic [4:0] MRA_SIZE_FULL_MAP = 5'h1f;  // 4 gb region, base ignored
   localparam logic [4:0] MRA_SIZE_MIN_SUB = 5'h07;   // smallest size with subregions
   localparam logic [31:0] MRA_FULL_MAP_BASE = 32'h00000000; // base of 4 gb region

   // ==========================================
   // reset values
   localparam logic [31:0] MRA_BASE_RESET = 32'h00000000;
   localparam logic [31:0] MRA_ATTR_RESET = 32'h00000000;
   localparam logic [3:0] MRA_REGION_RESET = 4'h0;

   // ==========================================
   // axi responses
   localparam logic [1:0] MRA_RESP_OKAY = 2'b00;
   localparam logic [1:0] MRA_RESP_SLVERR = 2'b10;

   // decoded register kind
   typedef enum logic [3:0] {
      MRA_REG_NONE = 4'b0001,
      MRA_REG_RNR = 4'b0010,
      MRA_REG_BASE = 4'b0100,
      MRA_REG_ATTR = 4'b1000
   } mra_reg_t;

   // result of a protection lookup
   typedef struct packed {
      logic hit;                    // some enabled region matched
      logic [3:0] region;           // winning region number
      logic fetch_blocked;          // instruction fetch refused
      logic [2:0] ap;               // access permission of winner
      logic [2:0] type_extension_field;              // type extension of winner
      logic s;                      // shareable
      logic c;                      // cacheable
      logic b;                      // bufferable
   } mra_check_t;

   // ==========================================
   // helper functions

   // map a byte address onto a register kind; aliases share kinds
   function automatic mra_reg_t mra_decode(input logic [7:0] addr);
      mra_reg_t k;
      k = MRA_REG_NONE;
      case (addr)
         MRA_OFS_REGION_NUMBER: k = MRA_REG_RNR;
         MRA_OFS_BASE, MRA_OFS_BASE_A1, MRA_OFS_BASE_A2, MRA_OFS_BASE_A3: k = MRA_REG_BASE;
         MRA_OFS_ATTR, MRA_OFS_ATTR_A1, MRA_OFS_ATTR_A2, MRA_OFS_ATTR_A3: k = MRA_REG_ATTR;
         default: k = MRA_REG_NONE;
      endcase
      return k;
   endfunction

   // replace only the byte lanes whose strobe is set
   function automatic logic [31:0] mra_merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                             input logic [3:0] strb);
      logic [31:0] r;
      r = old_v;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            r[i*8 +: 8] = new_v[i*8 +: 8];
         end
      end
      return r;
   endfunction

   // address bits 31:n compared for a region of 2^(size+1) bytes
   function automatic logic [31:0] mra_addr_mask(input logic [4:0] size);
      logic [31:0] low;
      low = (32'h00000001 << ({1'b0, size} + 6'd1)) - 32'h00000001;
      return (size == MRA_SIZE_FULL_MAP) ? 32'h00000000 : ~low;
   endfunction

endpackage
`default_nettype wire

// ===== design/mra_region_match.sv
// module: address match of one protection region, with size, base and subregion handling
`default_nettype none
module mra_region_match
   import mra_pkg::*;
(
   input wire logic [31:0] base,     // stored base register contents
   input wire logic [31:0] attr,     // stored attribute/size contents
   input wire logic [31:0] addr,     // address under check
   output logic hit                  // region claims the address
);

   // ==========================================
   // field extraction
   logic [4:0] size;                 // size field
   logic [7:0] subregion_disable_mask;                  // subregion_disable_mask
   logic enable;                     // region enable
   logic [31:0] eff_base;            // base actually used
   logic [31:0] shifted;             // address shifted to subregion index
   logic [2:0] sub_idx;              // subregion index inside region
   logic in_range;                   // address inside region span
   logic sub_off;                    // subregion disabled

   assign size = attr[MRA_ATTR_SIZE_LSB +: 5];
   assign subregion_disable_mask = attr[MRA_ATTR_SRD_LSB +: 8];
   assign enable = attr[MRA_ATTR_EN_BIT];

   // full-map size ignores the stored base and starts at zero
   assign eff_base = (size == MRA_SIZE_FULL_MAP) ? MRA_FULL_MAP_BASE : base; // R5

   // compare bits 31:n, n = log2 of 2^(size+1)
   assign in_range = ((addr ^ eff_base) & mra_addr_mask(size)) == 32'h00000000; // R3 R6

   // regions from MRA_SIZE_MIN_SUB up split in eight; index is the top three bits below n
   assign shifted = addr >> (size - 5'd2);
   assign sub_idx = shifted[2:0];

   // a set mask bit drops its subregion; small regions have none
   assign sub_off = (size >= MRA_SIZE_MIN_SUB) && subregion_disable_mask[sub_idx]; // R1

   // disabled regions take no part in matching
   assign hit = enable && in_range && !sub_off; // R17

endmodule
`default_nettype wire

// ===== design/mra_regs.sv
// module: axi4-lite register block for protection region descriptors with aliases and lookup
// Function
// R1 - mask bit one disables matching subregion
// R2 - regions up to 128 bytes: mask zero
// R3 - region size is two to size plus one
// R4 - software never programs below 32 bytes
// R5 - full-map size ignores base, starts zero
// R6 - address field is base bits 31:n
// R7 - software aligns base to region size
// R8 - valid zero: keep selector, write current
// R9 - valid one: load selector, write new region
// R10 - valid bit always reads as zero
// R11 - base read returns current selector value
// R12 - attr register takes word and halfword writes
// R13 - execute-never blocks instruction fetches
// R14 - attr field layout xn ap tex s c b
// R15 - base layout address, valid 4, region 3:0
// R16 - all aliases reach the same storage
// R17 - enable bit gates region matching
//
// The AXI4-Lite interface to the registers and the register addresses were decided locally.
`default_nettype none
module mra_regs
   import mra_pkg::*;
(
   input wire logic CLK_SYS,
   input wire logic RST,
   // ==========================================
   // axi4-lite write address
   input wire logic [7:0] S_AXI_AWADDR,
   input wire logic [2:0] S_AXI_AWPROT,
   input wire logic S_AXI_AWVALID,
   output logic S_AXI_AWREADY,
   // axi4-lite write data
   input wire logic [31:0] S_AXI_WDATA,
   input wire logic [3:0] S_AXI_WSTRB,
   input wire logic S_AXI_WVALID,
   output logic S_AXI_WREADY,
   // axi4-lite write response
   output logic [1:0] S_AXI_BRESP,
   output logic S_AXI_BVALID,
   input wire logic S_AXI_BREADY,
   // axi4-lite read address
   input wire logic [7:0] S_AXI_ARADDR,
   input wire logic [2:0] S_AXI_ARPROT,
   input wire logic S_AXI_ARVALID,
   output logic S_AXI_ARREADY,
   // axi4-lite read data
   output logic [31:0] S_AXI_RDATA,
   output logic [1:0] S_AXI_RRESP,
   output logic S_AXI_RVALID,
   input wire logic S_AXI_RREADY,
   // ==========================================
   // protection lookup port
   input wire logic [31:0] CHECK_ADDR,
   input wire logic CHECK_FETCH,
   output mra_check_t CHECK_RESULT
);

   // ==========================================
   // region storage
   logic [31:0] base_q [MRA_NUM_REGIONS];   // stored base words per region
   logic [31:0] attr_q [MRA_NUM_REGIONS];   // stored attribute/size words
   logic [3:0] rnr_q;                       // region_number_selector
   // low five base bits are never kept

   // ==========================================
   // write channel holding
   logic aw_full_q;                         // write address taken, not yet used
   logic [7:0] aw_addr_q;                   // held write address
   logic w_full_q;                          // write data taken, not yet used
   logic [31:0] w_data_q;                   // held write data
   logic [3:0] w_strb_q;                    // held write strobes
   logic bvalid_q;                          // write response pending
   logic [1:0] bresp_q;                     // write response code
   logic wr_fire;                           // both halves held: perform write
   mra_reg_t wr_kind;                       // decoded write target
   logic [3:0] wr_region;                   // region the base write lands in
   logic load_rnr;                          // base write moves the selector
   // base target: new region if valid set

   // ==========================================
   // read channel
   typedef enum logic [1:0] {
      MRA_RD_IDLE = 2'b01,
      MRA_RD_RESP = 2'b10
   } mra_rd_state_t;

   // one read at a time
   mra_rd_state_t rd_state_q;               // read channel state
   logic [31:0] rdata_q;                    // read data register
   logic [1:0] rresp_q;                     // read response code
   logic [31:0] rd_word;                    // data selected for a read
   mra_reg_t rd_kind;                       // decoded read target
   // read word is fixed at the taking edge

   // ==========================================
   // lookup
   // bit g from matcher g
   logic [MRA_NUM_REGIONS-1:0] hits;        // per-region match
   mra_check_t check_d;                     // lookup result before register
   mra_check_t check_q;                     // registered lookup result
   // one cycle of latency in the lookup

   // handshake outputs; a new item is taken only after the old is used
   assign S_AXI_AWREADY = !aw_full_q && !bvalid_q;
   assign S_AXI_WREADY = !w_full_q && !bvalid_q;
   assign S_AXI_ARREADY = (rd_state_q == MRA_RD_IDLE);
   // data and responses come from flops
   assign S_AXI_BVALID = bvalid_q;
   assign S_AXI_BRESP = bresp_q;
   assign S_AXI_RVALID = (rd_state_q == MRA_RD_RESP);
   assign S_AXI_RDATA = rdata_q;
   assign S_AXI_RRESP = rresp_q;
   assign CHECK_RESULT = check_q;

   // ==========================================
   // write decode

   // fires with both halves held
   assign wr_fire = aw_full_q && w_full_q && !bvalid_q;
   // aliases share one storage kind
   assign wr_kind = mra_decode(aw_addr_q); // R16

   // a base write moves the selector only when the region byte is written with valid set
   assign load_rnr = w_strb_q[0] && w_data_q[MRA_BASE_VALID_BIT]; // R9
   // valid clear keeps selector and ignores the written region field
   assign wr_region = load_rnr ? w_data_q[MRA_REGION_W-1:0] : rnr_q; // R8 R9

   // capture write address, hold until the write is performed
   always_ff @(posedge CLK_SYS or posedge RST) begin
      if (RST) begin
         aw_full_q <= 1'b0;
         aw_addr_q <= 8'h00;
      end else if (S_AXI_AWVALID && S_AXI_AWREADY) begin
         // slot stays full until the write
         aw_full_q <= 1'b1;
         aw_addr_q <= S_AXI_AWADDR;
      end else if (wr_fire) begin
         aw_full_q <= 1'b0;
      end
   end

   // capture write data and strobes, in either order to the address
   always_ff @(posedge CLK_SYS or posedge RST) begin
      if (RST) begin
         w_full_q <= 1'b0;
         w_data_q <= 32'h00000000;
         w_strb_q <= 4'h0;
      end else if (S_AXI_WVALID && S_AXI_WREADY) begin
         // strobes stay with their data
         w_full_q <= 1'b1;
         w_data_q <= S_AXI_WDATA;
         w_strb_q <= S_AXI_WSTRB;
      end else if (wr_fire) begin
         w_full_q <= 1'b0;
      end
   end

   // write response; unmapped offsets answer slave error
   always_ff @(posedge CLK_SYS or posedge RST) begin
      if (RST) begin
         bvalid_q <= 1'b0;
         bresp_q <= MRA_RESP_OKAY;
      end else if (wr_fire) begin
         bvalid_q <= 1'b1;
         bresp_q <= (wr_kind == MRA_REG_NONE) ? MRA_RESP_SLVERR : MRA_RESP_OKAY;
      end else if (bvalid_q && S_AXI_BREADY) begin
         // response taken; slots reopen
         bvalid_q <= 1'b0;
      end
   end

   // region number selector: direct write or base write with valid
   always_ff @(posedge CLK_SYS or posedge RST) begin
      if (RST) begin
         rnr_q <= MRA_REGION_RESET;
      end else if (wr_fire && wr_kind == MRA_REG_RNR && w_strb_q[0]) begin
         // direct selector write
         rnr_q <= w_data_q[MRA_REGION_W-1:0];
      end else if (wr_fire && wr_kind == MRA_REG_BASE && load_rnr) begin
         // base write with valid set
         rnr_q <= w_data_q[MRA_REGION_W-1:0]; // R9
      end
   end

   // base storage: address bits only, valid and region never stored
   always_ff @(posedge CLK_SYS or posedge RST) begin
      if (RST) begin
         for (int i = 0; i < MRA_NUM_REGIONS; i++) begin
            base_q[i] <= MRA_BASE_RESET;
         end
      end else if (wr_fire && wr_kind == MRA_REG_BASE) begin
         // target region from wr_region
         base_q[wr_region] <= mra_merge(base_q[wr_region], w_data_q, w_strb_q) & MRA_BASE_ADDR_MASK; // R6 R8 R15
      end
   end

   // attribute storage; strobes give word or halfword updates
   always_ff @(posedge CLK_SYS or posedge RST) begin
      if (RST) begin
         for (int i = 0; i < MRA_NUM_REGIONS; i++) begin
            attr_q[i] <= MRA_ATTR_RESET;
         end
      end else if (wr_fire && wr_kind == MRA_REG_ATTR) begin
         // attr follows the current selector
         attr_q[rnr_q] <= mra_merge(attr_q[rnr_q], w_data_q, w_strb_q) & MRA_ATTR_RW_MASK; // R12 R14
      end
   end

   // ==========================================
   // read path

   assign rd_kind = mra_decode(S_AXI_ARADDR); // R16
   // alias offsets decode alike

   // select the read word; reserved bits and valid read zero
   always_comb begin
      rd_word = 32'h00000000;
      // unmapped offsets read zero
      case (rd_kind)
         MRA_REG_RNR: rd_word = {28'h0000000, rnr_q};
         MRA_REG_BASE: rd_word = (base_q[rnr_q] & MRA_BASE_ADDR_MASK) | {28'h0000000, rnr_q}; // R10 R11 R15
         MRA_REG_ATTR: rd_word = attr_q[rnr_q] & MRA_ATTR_RW_MASK; // R14
         default: rd_word = 32'h00000000;
      endcase
   end

   // read channel: take address, present data until accepted
   always_ff @(posedge CLK_SYS or posedge RST) begin
      if (RST) begin
         rd_state_q <= MRA_RD_IDLE;
         rdata_q <= 32'h00000000;
         rresp_q <= MRA_RESP_OKAY;
      end else begin
         case (rd_state_q)
            MRA_RD_IDLE: begin
               // arready high: arvalid alone takes it
               if (S_AXI_ARVALID) begin
                  rd_state_q <= MRA_RD_RESP;
                  rdata_q <= rd_word;
                  rresp_q <= (rd_kind == MRA_REG_NONE) ? MRA_RESP_SLVERR : MRA_RESP_OKAY;
               end
            end
            MRA_RD_RESP: begin
               // hold until rready
               if (S_AXI_RREADY) begin
                  rd_state_q <= MRA_RD_IDLE;
               end
            end
            default: begin
               rd_state_q <= MRA_RD_IDLE;
            end
         endcase
      end
   end

   // ==========================================
   // protection lookup

   // one matcher per region over the shared storage
   for (genvar g = 0; g < MRA_NUM_REGIONS; g++) begin : g_match
      // all matchers see one address
      mra_region_match u_match (
         .base(base_q[g]),
         .attr(attr_q[g]),
         .addr(CHECK_ADDR),
         .hit(hits[g])
      );
   end

   // highest numbered matching region wins
   always_comb begin
      check_d = '0;
      // later regions override, highest wins
      for (int i = 0; i < MRA_NUM_REGIONS; i++) begin
         if (hits[i]) begin
            check_d.hit = 1'b1;
            check_d.region = i[3:0];
            check_d.fetch_blocked = CHECK_FETCH && attr_q[i][MRA_ATTR_XN_BIT]; // R13
            // only fetches are ever blocked
            check_d.ap = attr_q[i][MRA_ATTR_AP_LSB +: 3];
            check_d.type_extension_field = attr_q[i][MRA_ATTR_TEX_LSB +: 3];
            check_d.s = attr_q[i][MRA_ATTR_S_BIT];
            check_d.c = attr_q[i][MRA_ATTR_C_BIT];
            check_d.b = attr_q[i][MRA_ATTR_B_BIT];
         end
      end
   end

   // lookup result registered one cycle after the address
   always_ff @(posedge CLK_SYS or posedge RST) begin
      if (RST) begin
         check_q <= '0;
      end else begin
         check_q <= check_d;
         // updates every cycle
      end
   end

endmodule
`default_nettype wire

// ===== test/mra_regs_chk.sv
// checker: handshake, response and lookup relations at the region register block ports
`default_nettype none
module mra_regs_chk
   import mra_pkg::*;
(
   input wire logic CLK_SYS,
   input wire logic RST,
   input wire logic S_AXI_AWVALID,
   input wire logic S_AXI_AWREADY,
   input wire logic S_AXI_WVALID,
   input wire logic S_AXI_WREADY,
   input wire logic [1:0] S_AXI_BRESP,
   input wire logic S_AXI_BVALID,
   input wire logic S_AXI_BREADY,
   input wire logic [7:0] S_AXI_ARADDR,
   input wire logic S_AXI_ARVALID,
   input wire logic S_AXI_ARREADY,
   input wire logic [31:0] S_AXI_RDATA,
   input wire logic [1:0] S_AXI_RRESP,
   input wire logic S_AXI_RVALID,
   input wire logic S_AXI_RREADY,
   input wire logic CHECK_FETCH,
   input wire mra_check_t CHECK_RESULT
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge CLK_SYS); endclocking
   default disable iff (RST);
   logic is_base_q; // the read under way targets a base register or alias
   logic ar_hs; // read address taken this cycle
   logic wr_hs; // address and data taken together
   assign ar_hs = S_AXI_ARVALID && S_AXI_ARREADY;
   assign wr_hs = S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY;
   // =====================================
   // helper: remember the kind of the read address
   always_ff @(posedge CLK_SYS or posedge RST) begin
      if (RST) begin
         is_base_q <= 1'b0;
      end else if (ar_hs) begin
         is_base_q <= (S_AXI_ARADDR == 8'h04) || (S_AXI_ARADDR == 8'h0c) ||
                      (S_AXI_ARADDR == 8'h14) || (S_AXI_ARADDR == 8'h1c);
      end
   end
   // =====================================
   // assertions
   a_bresp_stands: assert property (S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID && $stable(S_AXI_BRESP))
      else $error("write response dropped early");
   a_rdata_stands: assert property (S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA))
      else $error("read data dropped early");
   a_write_refused: assert property (S_AXI_BVALID |-> !S_AXI_AWREADY && !S_AXI_WREADY)
      else $error("write taken while response pending");
   a_read_answer: assert property (ar_hs |=> S_AXI_RVALID && !S_AXI_ARREADY)
      else $error("read answer late");
   a_write_answer: assert property (wr_hs |-> ##2 S_AXI_BVALID)
      else $error("write answer late");
   a_unmapped_read: assert property (ar_hs && S_AXI_ARADDR > 8'h20 |=>
      S_AXI_RRESP == MRA_RESP_SLVERR && S_AXI_RDATA == 32'h00000000)
      else $error("unmapped read not refused");
   a_valid_reads_zero: assert property (S_AXI_RVALID && is_base_q |-> S_AXI_RDATA[4] == 1'b0)
      else $error("valid bit read as one");
   a_fetch_blocked: assert property (CHECK_RESULT.fetch_blocked |-> CHECK_RESULT.hit && $past(CHECK_FETCH))
      else $error("fetch block without fetch or hit");
   a_miss_clean: assert property (!CHECK_RESULT.hit |-> CHECK_RESULT == '0)
      else $error("miss result not clear");
   c_fetch_block: cover property (CHECK_RESULT.fetch_blocked);
   c_unmapped: cover property (ar_hs && S_AXI_ARADDR > 8'h20);
   c_write: cover property (wr_hs ##2 S_AXI_BVALID);
endmodule
bind mra_regs mra_regs_chk u_chk (.CLK_SYS(CLK_SYS), .RST(RST), .S_AXI_AWVALID(S_AXI_AWVALID),
   .S_AXI_AWREADY(S_AXI_AWREADY), .S_AXI_WVALID(S_AXI_WVALID), .S_AXI_WREADY(S_AXI_WREADY),
   .S_AXI_BRESP(S_AXI_BRESP), .S_AXI_BVALID(S_AXI_BVALID), .S_AXI_BREADY(S_AXI_BREADY),
   .S_AXI_ARADDR(S_AXI_ARADDR), .S_AXI_ARVALID(S_AXI_ARVALID), .S_AXI_ARREADY(S_AXI_ARREADY),
   .S_AXI_RDATA(S_AXI_RDATA), .S_AXI_RRESP(S_AXI_RRESP), .S_AXI_RVALID(S_AXI_RVALID),
   .S_AXI_RREADY(S_AXI_RREADY), .CHECK_FETCH(CHECK_FETCH), .CHECK_RESULT(CHECK_RESULT));
`default_nettype wire

// ===== test/tb.sv
// testbench: axi4-lite register sequences and lookups for the region register block
`default_nettype none
module tb
   import mra_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic CLK_SYS = 1'b0, RST = 1'b1;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic [31:0] wdata = 32'h00000000, rdata, check_addr = 32'h00000000;
   logic [3:0] wstrb = 4'h0;
   logic check_fetch = 1'b0;
   logic [8:0] exp_attr = 9'h000; // ap, tex, s, c, b of a hit
   logic awready, wready, bvalid, arready, rvalid;
   logic [1:0] bresp, rresp;
   mra_check_t res;
   int n_errors = 0, total_checks = 0;
   // =====================================
   // clock and device
   initial begin
      forever #4 CLK_SYS = ~CLK_SYS;
   end
   mra_regs DUT (.CLK_SYS(CLK_SYS), .RST(RST), .S_AXI_AWADDR(awaddr), .S_AXI_AWPROT(3'h0),
      .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb),
      .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid),
      .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr), .S_AXI_ARPROT(3'h0), .S_AXI_ARVALID(arvalid),
      .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid),
      .S_AXI_RREADY(rready), .CHECK_ADDR(check_addr), .CHECK_FETCH(check_fetch), .CHECK_RESULT(res));
   // =====================================
   // verdict and comparison helpers
   task automatic report_and_stop();
      if (n_errors == 0 && total_checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic hang();
      n_errors++;
      report_and_stop();
   endtask
   // =====================================
   // bus tasks, entered just after a rising edge
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] er);
      logic ha, hw, da, dw, hb;
      da = 1'b0;
      dw = 1'b0;
      awaddr <= a;
      wdata <= d;
      wstrb <= s;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      for (int i = 0; i < 50 && !(da && dw); i++) begin
         @(negedge CLK_SYS);
         ha = awvalid && awready;
         hw = wvalid && wready;
         @(posedge CLK_SYS);
         if (ha) awvalid <= 1'b0;
         if (hw) wvalid <= 1'b0;
         da = da | ha;
         dw = dw | hw;
      end
      if (!(da && dw)) hang();
      bready <= 1'b1;
      hb = 1'b0;
      for (int i = 0; i < 50 && !hb; i++) begin
         @(negedge CLK_SYS);
         hb = bvalid;
         if (hb) chk({30'h0, bresp}, {30'h0, er});
         @(posedge CLK_SYS);
      end
      bready <= 1'b0;
      if (!hb) hang();
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
      logic ha, hr;
      ha = 1'b0;
      hr = 1'b0;
      araddr <= a;
      arvalid <= 1'b1;
      for (int i = 0; i < 50 && !ha; i++) begin
         @(negedge CLK_SYS);
         ha = arready;
         @(posedge CLK_SYS);
      end
      arvalid <= 1'b0;
      rready <= 1'b1;
      for (int i = 0; i < 50 && ha && !hr; i++) begin
         @(negedge CLK_SYS);
         hr = rvalid;
         if (hr) chk(rdata, exp);
         if (hr) chk({30'h0, rresp}, {30'h0, er});
         @(posedge CLK_SYS);
      end
      rready <= 1'b0;
      if (!hr) hang();
   endtask
   // lookup: result shown one cycle after the address; compares hit, region, fetch block, then ap, tex, s, c, b of the winner
   task automatic look(input logic [31:0] a, input logic f, input logic [5:0] exp);
      check_addr <= a;
      check_fetch <= f;
      @(posedge CLK_SYS);
      @(negedge CLK_SYS);
      chk({26'h0, res.hit, res.region, res.fetch_blocked}, {26'h0, exp});
      chk({23'h0, res.ap, res.type_extension_field, res.s, res.c, res.b}, {23'h0, (exp[5] ? exp_attr : 9'h000)});
      @(posedge CLK_SYS);
   endtask
   // =====================================
   // main sequence
   initial begin
      repeat (8) @(posedge CLK_SYS);
      RST <= 1'b0;
      @(posedge CLK_SYS);
      rd(MRA_OFS_ATTR, MRA_ATTR_RESET, MRA_RESP_OKAY);
      rd(MRA_OFS_REGION_NUMBER, 32'h00000000, MRA_RESP_OKAY);
      wr(MRA_OFS_BASE_A2, 32'h20001015, 4'hf, MRA_RESP_OKAY);
      rd(MRA_OFS_BASE_A3, 32'h20001005, MRA_RESP_OKAY);
      rd(MRA_OFS_REGION_NUMBER, 32'h00000005, MRA_RESP_OKAY);
      wr(MRA_OFS_BASE_A3, 32'h30000003, 4'hf, MRA_RESP_OKAY);
      rd(MRA_OFS_REGION_NUMBER, 32'h00000005, MRA_RESP_OKAY);
      rd(MRA_OFS_BASE, 32'h30000005, MRA_RESP_OKAY);
      wr(MRA_OFS_BASE_A1, 32'h20001003, 4'hf, MRA_RESP_OKAY);
      wr(MRA_OFS_ATTR_A2, 32'hffffffff, 4'hf, MRA_RESP_OKAY);
      rd(MRA_OFS_ATTR_A3, 32'h173fff3f, MRA_RESP_OKAY);
      wr(MRA_OFS_ATTR_A2, 32'h00000013, 4'h3, MRA_RESP_OKAY);
      rd(MRA_OFS_ATTR_A2, 32'h173f0013, MRA_RESP_OKAY);
      wr(MRA_OFS_ATTR_A3, 32'h130f0000, 4'hc, MRA_RESP_OKAY);
      rd(MRA_OFS_ATTR, 32'h130f0013, MRA_RESP_OKAY);
      exp_attr = 9'h0cf;
      look(32'h20001010, 1'b1, {1'b1, 4'h5, 1'b1});
      look(32'h20001010, 1'b0, {1'b1, 4'h5, 1'b0});
      look(32'h200013fc, 1'b0, {1'b1, 4'h5, 1'b0});
      look(32'h20001400, 1'b1, 6'h00);
      look(32'h20000ffc, 1'b0, 6'h00);
      wr(MRA_OFS_ATTR_A2, 32'h130f0413, 4'hf, MRA_RESP_OKAY);
      look(32'h20001100, 1'b0, 6'h00);
      look(32'h20001080, 1'b0, {1'b1, 4'h5, 1'b0});
      look(32'h2000117c, 1'b0, 6'h00);
      look(32'h20001180, 1'b0, {1'b1, 4'h5, 1'b0});
      wr(MRA_OFS_ATTR_A3, 32'h0000003f, 4'hf, MRA_RESP_OKAY);
      exp_attr = 9'h000;
      look(32'h80000000, 1'b1, {1'b1, 4'h5, 1'b0});
      look(32'h00000000, 1'b0, {1'b1, 4'h5, 1'b0});
      wr(MRA_OFS_ATTR_A3, 32'h1000003e, 4'hf, MRA_RESP_OKAY);
      look(32'h80000000, 1'b1, 6'h00);
      rd(8'h24, 32'h00000000, MRA_RESP_SLVERR);
      wr(8'h24, 32'h00000015, 4'hf, MRA_RESP_SLVERR);
      rd(MRA_OFS_REGION_NUMBER, 32'h00000005, MRA_RESP_OKAY);
      wr(MRA_OFS_REGION_NUMBER, 32'h0000000a, 4'h1, MRA_RESP_OKAY);
      rd(MRA_OFS_BASE_A2, 32'h0000000a, MRA_RESP_OKAY);
      report_and_stop();
   end
endmodule
`default_nettype wire
